/* File: pwmg_ch_if.sv */
// control and status bundle between the group and one channel timer
// assumes one instance per channel, driven on the group clock
`timescale 1ns/100ps
`default_nettype none
`include "pwmg_map.svh"

interface pwmg_ch_if;
    logic tick;
    logic enable;
    logic reload;
    logic cap_en;
    logic rise_ie;
    logic fall_ie;
    logic cap_in;
    logic [`PWMG_CNT_W-1:0] period;
    logic [`PWMG_CNT_W-1:0] compare;
    logic [`PWMG_CNT_W-1:0] cnt;
    logic [`PWMG_CNT_W-1:0] rise_val;
    logic [`PWMG_CNT_W-1:0] fall_val;
    logic wave;
    logic period_evt;
    logic cap_evt;
    modport ctl(output tick, enable, reload, cap_en, rise_ie, fall_ie, cap_in, period, compare,
        input cnt, rise_val, fall_val, wave, period_evt, cap_evt);
    modport chan(input tick, enable, reload, cap_en, rise_ie, fall_ie, cap_in, period, compare,
        output cnt, rise_val, fall_val, wave, period_evt, cap_evt);
endinterface

`default_nettype wire

/* File: pwmg_chan.sv */
// one channel timer: period down-counter, compare, capture latches
// assumes cap_in already synchronised and tick a one-cycle enable
`timescale 1ns/100ps
`default_nettype none
`include "pwmg_map.svh"

module pwmg_chan
    import pwmg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    pwmg_ch_if.chan ch
);

    pwmg_chan_s st;
    pwmg_chan_s next_st;
    logic [`PWMG_CNT_W-1:0] cnt_m1;
    logic rise;
    logic fall;

    assign cnt_m1 = st.cnt - `PWMG_CNT_W'(1);
    assign rise = ch.cap_en && ch.cap_in && !st.cap_d;
    assign fall = ch.cap_en && !ch.cap_in && st.cap_d;

    always_comb begin
        next_st = st;
        next_st.period_evt = 1'b0;
        next_st.cap_evt = 1'b0;
        next_st.cap_d = ch.cap_in;
        next_st.en_d = ch.enable;
        if (!ch.enable) begin
            next_st.run = 1'b0;
            next_st.wave = 1'b0;
        end else if (!st.en_d) begin
            next_st.cnt = ch.period;
            next_st.run = 1'b1;
            next_st.wave = 1'b0;
        end else if (st.run && ch.tick) begin
            if (st.cnt == '0) begin
                next_st.period_evt = 1'b1;
                next_st.wave = 1'b0;
                if (ch.reload) begin
                    next_st.cnt = ch.period;
                end else begin
                    next_st.run = 1'b0;
                end
            end else begin
                next_st.cnt = cnt_m1;
                if (cnt_m1 == ch.compare) begin
                    next_st.wave = 1'b1;
                end
            end
        end
        // capture uses this channel's own counter
        if (rise) begin
            next_st.rise_val = st.cnt;
        end
        if (fall) begin
            next_st.fall_val = st.cnt;
        end
        if ((rise && ch.rise_ie) || (fall && ch.fall_ie)) begin
            next_st.cap_evt = 1'b1;
            next_st.cnt = ch.period;
            next_st.wave = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ch.cnt = st.cnt;
    assign ch.rise_val = st.rise_val;
    assign ch.fall_val = st.fall_val;
    assign ch.wave = st.wave;
    assign ch.period_evt = st.period_evt;
    assign ch.cap_evt = st.cap_evt;

endmodule

`default_nettype wire

/* File: pwmg_map.svh */
// register offsets, field positions, reset values and sizes of the pwm group
// assumes inclusion by bare name from the package and the design modules
`ifndef PWMG_MAP_SVH
`define PWMG_MAP_SVH

`define PWMG_NCH 8
`define PWMG_NGEN 4
`define PWMG_CNT_W 16

// ****************************************************************
// register offsets, byte addresses
// ****************************************************************
`define PWMG_OFS_PRESCALE 8'h00
`define PWMG_OFS_CLKDIV 8'h04
`define PWMG_OFS_CTRL 8'h08
`define PWMG_OFS_DEADTIME 8'h0C
`define PWMG_OFS_IRQ_EN 8'h10
`define PWMG_OFS_INDICATOR 8'h14
`define PWMG_BANK_MISC 3'h0
`define PWMG_BANK_PERIOD 3'h1
`define PWMG_BANK_COMPARE 3'h2
`define PWMG_BANK_COUNT 3'h3
`define PWMG_BANK_RISE 3'h4
`define PWMG_BANK_FALL 3'h5
`define PWMG_BANK_CAPCTL 3'h6

// ****************************************************************
// field positions
// ****************************************************************
`define PWMG_CTRL_EN_LSB 0
`define PWMG_CTRL_RELOAD_LSB 8
`define PWMG_CTRL_DZEN_LSB 16
`define PWMG_CAP_EN_BIT 0
`define PWMG_CAP_RISE_IE_BIT 1
`define PWMG_CAP_FALL_IE_BIT 2
`define PWMG_CAP_FLAG_BIT 4
`define PWMG_CAP_HALF 16
`define PWMG_IND_CAP_LSB 8
`define PWMG_DIV_MAX_CODE 3'h4

// ****************************************************************
// reset values
// ****************************************************************
`define PWMG_RST_WORD 32'h0000_0000
`define PWMG_RST_PERIOD 16'hFFFF
`define PWMG_RST_COMPARE 16'h0000

`endif

/* File: pwmg_pins.sv */
// model of the pins beyond the group: loads and capture sources
// assumes the bench sets src_level for pins whose driver is off
`timescale 1ns/100ps
`default_nettype none

module pwmg_pins (
    input wire logic [7:0] pwm_out,
    input wire logic [7:0] pwm_oe,
    input wire logic [7:0] src_level,
    output logic [7:0] cap_in
);
    // ****************************************************************
    // pin level
    // ****************************************************************
    // group wins while it drives, else the outside source
    assign cap_in = (pwm_oe & pwm_out) | (~pwm_oe & src_level);
endmodule

`default_nettype wire

/* File: pwmg_pkg.sv */
// state types of the pwm group and its channel timers
// assumes pwmg_map.svh on the include path
`include "pwmg_map.svh"

package pwmg_pkg;

    typedef struct packed {
        logic [`PWMG_CNT_W-1:0] cnt;
        logic [`PWMG_CNT_W-1:0] rise_val;
        logic [`PWMG_CNT_W-1:0] fall_val;
        logic run;
        logic wave;
        logic en_d;
        logic cap_d;
        logic period_evt;
        logic cap_evt;
    } pwmg_chan_s;

    typedef struct packed {
        logic [`PWMG_NGEN-1:0][7:0] presc_cnt;
        logic [`PWMG_NGEN-1:0][3:0] div_cnt;
        logic [`PWMG_NGEN-1:0][7:0] prescale;
        logic [`PWMG_NGEN-1:0][2:0] clk_div;
        logic [`PWMG_NCH-1:0] ch_en;
        logic [`PWMG_NCH-1:0] reload;
        logic [`PWMG_NGEN-1:0] dz_en;
        logic [`PWMG_NGEN-1:0][7:0] dead;
        logic [`PWMG_NCH-1:0][`PWMG_CNT_W-1:0] period;
        logic [`PWMG_NCH-1:0][`PWMG_CNT_W-1:0] compare;
        logic [`PWMG_NCH-1:0] pie;
        logic [`PWMG_NCH-1:0] pflag;
        logic [`PWMG_NCH-1:0] cflag;
        logic [`PWMG_NCH-1:0] cap_en;
        logic [`PWMG_NCH-1:0] rise_ie;
        logic [`PWMG_NCH-1:0] fall_ie;
        logic [`PWMG_NCH-1:0][7:0] dz_cnt;
        logic [`PWMG_NCH-1:0] out;
        logic [`PWMG_NCH-1:0] cap_s1;
        logic [`PWMG_NCH-1:0] cap_s2;
        logic [31:0] rd_data;
    } pwmg_top_s;

endpackage

/* File: pwmg_top.sv */
// pwm group: four generators, eight channels, dead zone, capture, registers
// assumes a plain register port on clk and asynchronous capture pins
`timescale 1ns/100ps
`default_nettype none
`include "pwmg_map.svh"

module pwmg_top
    import pwmg_pkg::*;
#(
    parameter int CNT_W = `PWMG_CNT_W
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    input wire logic [`PWMG_NCH-1:0] cap_in,
    output logic [`PWMG_NCH-1:0] pwm_out,
    output logic [`PWMG_NCH-1:0] pwm_oe,
    output logic irq
);

    generate
        if (CNT_W != `PWMG_CNT_W) begin : g_bad_width
            $error("pwmg_top: counter width must match the package");
        end
    endgenerate

    pwmg_top_s st;
    pwmg_top_s next_st;

    logic [`PWMG_NGEN-1:0] gen_tick;
    logic [`PWMG_NCH-1:0][CNT_W-1:0] cnt_a;
    logic [`PWMG_NCH-1:0][CNT_W-1:0] rise_a;
    logic [`PWMG_NCH-1:0][CNT_W-1:0] fall_a;
    logic [`PWMG_NCH-1:0] wave_a;
    logic [`PWMG_NCH-1:0] pevt_a;
    logic [`PWMG_NCH-1:0] cevt_a;
    logic [2:0] bank;
    logic [2:0] idx;

    assign bank = addr[7:5];
    assign idx = addr[4:2];

    function automatic logic [3:0] div_mask(input logic [2:0] code);
        logic [3:0] m;
        m = 4'hF;
        case (code)
            3'h0: m = 4'h0;
            3'h1: m = 4'h1;
            3'h2: m = 4'h3;
            3'h3: m = 4'h7;
            default: m = 4'hF;
        endcase
        return m;
    endfunction

    // ****************************************************************
    // generator ticks and channel timers
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < `PWMG_NGEN; gi++) begin : g_gen
            assign gen_tick[gi] = (st.presc_cnt[gi] == st.prescale[gi]) &&
                ((st.div_cnt[gi] & div_mask(st.clk_div[gi])) ==
                div_mask(st.clk_div[gi]));
        end
        for (gi = 0; gi < `PWMG_NCH; gi++) begin : g_ch
            pwmg_ch_if ch_if();
            assign ch_if.tick = gen_tick[gi / 2];
            assign ch_if.enable = st.ch_en[gi];
            assign ch_if.reload = st.reload[gi];
            assign ch_if.cap_en = st.cap_en[gi];
            assign ch_if.rise_ie = st.rise_ie[gi];
            assign ch_if.fall_ie = st.fall_ie[gi];
            assign ch_if.cap_in = st.cap_s2[gi];
            assign ch_if.period = st.period[gi];
            assign ch_if.compare = st.compare[gi];
            assign cnt_a[gi] = ch_if.cnt;
            assign rise_a[gi] = ch_if.rise_val;
            assign fall_a[gi] = ch_if.fall_val;
            assign wave_a[gi] = ch_if.wave;
            assign pevt_a[gi] = ch_if.period_evt;
            assign cevt_a[gi] = ch_if.cap_evt;
            pwmg_chan u_chan (
                .clk(clk),
                .rst_b(rst_b),
                .ch(ch_if.chan)
            );
        end
    endgenerate

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        int p;
        logic want;
        logic [31:0] rd;
        p = 0;
        want = 1'b0;
        rd = '0;
        next_st = st;
        next_st.cap_s1 = cap_in;
        next_st.cap_s2 = st.cap_s1;

        for (int g = 0; g < `PWMG_NGEN; g++) begin
            if (st.presc_cnt[g] == st.prescale[g]) begin
                next_st.presc_cnt[g] = 8'h00;
                next_st.div_cnt[g] = st.div_cnt[g] + 4'h1;
            end else begin
                next_st.presc_cnt[g] = st.presc_cnt[g] + 8'h01;
            end
        end

        // outputs, with dead zone on enabled pairs
        for (int i = 0; i < `PWMG_NCH; i++) begin
            p = i / 2;
            if (st.dz_en[p]) begin
                // odd timer ignored, both follow the even wave, the odd one inverted
                if (i % 2 == 0) begin
                    want = wave_a[i];
                end else begin
                    want = st.ch_en[i - 1] && !wave_a[i - 1];
                end
                if (!want) begin
                    next_st.dz_cnt[i] = 8'h00;
                    next_st.out[i] = 1'b0;
                end else if (st.dz_cnt[i] < st.dead[p]) begin
                    next_st.dz_cnt[i] = st.dz_cnt[i] + 8'h01;
                    next_st.out[i] = 1'b0;
                end else begin
                    next_st.out[i] = 1'b1;
                end
            end else begin
                next_st.dz_cnt[i] = 8'h00;
                next_st.out[i] = wave_a[i];
            end
        end

        // flags: hardware set wins over the write-one clear
        next_st.pflag = st.pflag | pevt_a;
        next_st.cflag = st.cflag | cevt_a;
        if (wr_en && addr == `PWMG_OFS_INDICATOR) begin
            next_st.pflag = (st.pflag & ~wr_data[7:0]) | pevt_a;
            next_st.cflag = (st.cflag & ~wr_data[15:8]) | cevt_a;
        end

        // ****************************************************************
        // register writes
        // ****************************************************************
        if (wr_en) begin
            unique case (bank)
                `PWMG_BANK_MISC: begin
                    case (addr)
                        `PWMG_OFS_PRESCALE: next_st.prescale = wr_data;
                        `PWMG_OFS_CLKDIV: begin
                            for (int g = 0; g < `PWMG_NGEN; g++) begin
                                next_st.clk_div[g] = (wr_data[g*4 +: 3] > `PWMG_DIV_MAX_CODE)
                                    ? `PWMG_DIV_MAX_CODE : wr_data[g*4 +: 3];
                            end
                        end
                        `PWMG_OFS_CTRL: begin
                            next_st.ch_en = wr_data[`PWMG_CTRL_EN_LSB +: 8];
                            next_st.reload = wr_data[`PWMG_CTRL_RELOAD_LSB +: 8];
                            next_st.dz_en = wr_data[`PWMG_CTRL_DZEN_LSB +: 4];
                        end
                        `PWMG_OFS_DEADTIME: next_st.dead = wr_data;
                        `PWMG_OFS_IRQ_EN: next_st.pie = wr_data[7:0];
                        default: ;
                    endcase
                end
                `PWMG_BANK_PERIOD: next_st.period[idx] = wr_data[CNT_W-1:0];
                `PWMG_BANK_COMPARE: next_st.compare[idx] = wr_data[CNT_W-1:0];
                `PWMG_BANK_CAPCTL: begin
                    if (idx < 3'h4) begin
                        // two channels per register, second at bit 16
                        for (int h = 0; h < 2; h++) begin
                            p = 2 * int'(idx) + h;
                            next_st.cap_en[p] =
                                wr_data[h*`PWMG_CAP_HALF + `PWMG_CAP_EN_BIT];
                            next_st.rise_ie[p] =
                                wr_data[h*`PWMG_CAP_HALF + `PWMG_CAP_RISE_IE_BIT];
                            next_st.fall_ie[p] =
                                wr_data[h*`PWMG_CAP_HALF + `PWMG_CAP_FALL_IE_BIT];
                        end
                    end
                end
                default: ;
            endcase
        end

        // ****************************************************************
        // register reads, data one cycle after the strobe
        // ****************************************************************
        unique case (bank)
            `PWMG_BANK_MISC: begin
                case (addr)
                    `PWMG_OFS_PRESCALE: rd = st.prescale;
                    `PWMG_OFS_CLKDIV: begin
                        for (int g = 0; g < `PWMG_NGEN; g++) begin
                            rd[g*4 +: 3] = st.clk_div[g];
                        end
                    end
                    `PWMG_OFS_CTRL: begin
                        rd[`PWMG_CTRL_EN_LSB +: 8] = st.ch_en;
                        rd[`PWMG_CTRL_RELOAD_LSB +: 8] = st.reload;
                        rd[`PWMG_CTRL_DZEN_LSB +: 4] = st.dz_en;
                    end
                    `PWMG_OFS_DEADTIME: rd = st.dead;
                    `PWMG_OFS_IRQ_EN: rd[7:0] = st.pie;
                    `PWMG_OFS_INDICATOR: begin
                        rd[7:0] = st.pflag;
                        rd[`PWMG_IND_CAP_LSB +: 8] = st.cflag;
                    end
                    default: rd = '0;
                endcase
            end
            `PWMG_BANK_PERIOD: rd[CNT_W-1:0] = st.period[idx];
            `PWMG_BANK_COMPARE: rd[CNT_W-1:0] = st.compare[idx];
            `PWMG_BANK_COUNT: rd[CNT_W-1:0] = cnt_a[idx];
            `PWMG_BANK_RISE: rd[CNT_W-1:0] = rise_a[idx];
            `PWMG_BANK_FALL: rd[CNT_W-1:0] = fall_a[idx];
            `PWMG_BANK_CAPCTL: begin
                if (idx < 3'h4) begin
                    for (int h = 0; h < 2; h++) begin
                        p = 2 * int'(idx) + h;
                        rd[h*`PWMG_CAP_HALF + `PWMG_CAP_EN_BIT] = st.cap_en[p];
                        rd[h*`PWMG_CAP_HALF + `PWMG_CAP_RISE_IE_BIT] = st.rise_ie[p];
                        rd[h*`PWMG_CAP_HALF + `PWMG_CAP_FALL_IE_BIT] = st.fall_ie[p];
                        rd[h*`PWMG_CAP_HALF + `PWMG_CAP_FLAG_BIT] = st.cflag[p];
                    end
                end
            end
            default: rd = '0;
        endcase
        next_st.rd_data = rd_en ? rd : '0;
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st <= '0;
            st.prescale <= `PWMG_RST_WORD;
            st.dead <= `PWMG_RST_WORD;
            for (int i = 0; i < `PWMG_NCH; i++) begin
                st.period[i] <= `PWMG_RST_PERIOD;
                st.compare[i] <= `PWMG_RST_COMPARE;
            end
        end else begin
            st <= next_st;
        end
    end

    assign rd_data = st.rd_data;
    assign pwm_out = st.out & ~st.cap_en;
    assign pwm_oe = ~st.cap_en;
    assign irq = |(st.pflag & st.pie) || |st.cflag;

endmodule

`default_nettype wire

/* File: pwmg_top_assertions.sv */
// port-level checker of the pwm group
// assumes binding onto pwmg_top with its plain register port
`timescale 1ns/100ps
`default_nettype none
`include "pwmg_map.svh"

module pwmg_top_assertions #(
    parameter int CNT_W = `PWMG_CNT_W
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rd_data,
    input wire logic [`PWMG_NCH-1:0] cap_in,
    input wire logic [`PWMG_NCH-1:0] pwm_out,
    input wire logic [`PWMG_NCH-1:0] pwm_oe,
    input wire logic irq
);
    // ****************************************************************
    // shadows of written control fields
    // ****************************************************************
    logic [7:0] en_q;
    logic [7:0] pie_q;
    logic [7:0] cap_q;
    logic [3:0] dz_q;
    logic [7:0] cie_q;
    logic cie_ever;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            en_q <= 8'h00;
            pie_q <= 8'h00;
            cap_q <= 8'h00;
            dz_q <= 4'h0;
            cie_q <= 8'h00;
            cie_ever <= 1'b0;
        end else begin
            // capture flags may be pending until all are cleared with no enable set
            if (wr_en && addr == 8'h14 && wr_data[15:8] == 8'hFF && cie_q == 8'h00) begin
                cie_ever <= 1'b0;
            end else if (cie_q != 8'h00) begin
                cie_ever <= 1'b1;
            end
            if (wr_en) begin
                if (addr == 8'h08) begin
                    en_q <= wr_data[7:0];
                    dz_q <= wr_data[19:16];
                end
                if (addr == 8'h10) begin
                    pie_q <= wr_data[7:0];
                end
                if (addr[7:4] == 4'hC && addr[1:0] == 2'b00) begin
                    cap_q[{addr[3:2], 1'b0}] <= wr_data[0];
                    cap_q[{addr[3:2], 1'b1}] <= wr_data[16];
                    cie_q[{addr[3:2], 1'b0}] <= |wr_data[2:1];
                    cie_q[{addr[3:2], 1'b1}] <= |wr_data[18:17];
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    reset_outputs_a: assert property ($rose(rst_b) |-> pwm_out == 8'h00 && pwm_oe == 8'hFF && !irq)
        else $error("outputs not at reset level");
    read_idle_a: assert property (!$past(rd_en) |-> rd_data == 32'h0000_0000)
        else $error("read data outside its cycle");
    unmapped_read_a: assert property (rd_en && addr == 8'hF0 |=> rd_data == 32'h0000_0000)
        else $error("unmapped read not zero");
    oe_gates_out_a: assert property ((pwm_out & ~pwm_oe) == 8'h00)
        else $error("output high while not driven");
    oe_follows_cap_a: assert property (cap_q == $past(cap_q) |-> pwm_oe == ~cap_q)
        else $error("output enable not following capture enable");
    irq_masked_a: assert property (pie_q == 8'h00 && $past(pie_q) == 8'h00 && !cie_ever |-> !irq)
        else $error("interrupt raised while masked");
    irq_fall_cause_a: assert property ($fell(irq) |-> $past(wr_en) || $past(wr_en, 2))
        else $error("interrupt dropped without a write");
    for (genvar p = 0; p < 4; p++) begin : g_pair
        pair_exclusive_a: assert property (dz_q[p] && $past(dz_q[p], 2) |-> !(pwm_out[2*p] && pwm_out[2*p+1]))
            else $error("both outputs of a pair high");
        pair_odd_idle_a: assert property (dz_q[p] && !en_q[2*p] && $past(dz_q[p] && !en_q[2*p], 4) |-> !pwm_out[2*p+1])
            else $error("odd output of a pair runs on its own timer");
    end
endmodule

bind pwmg_top pwmg_top_assertions #(.CNT_W(CNT_W)) u_chk (.clk(clk), .rst_b(rst_b), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .cap_in(cap_in),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq));

`default_nettype wire

/* File: pwmg_top_tb.sv */
// self-checking bench of the pwm group
// assumes pwmg_top, its checker bind and the pin model in the same compile
`timescale 1ns/100ps
`default_nettype none
`include "pwmg_map.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin failures++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end

module pwmg_top_tb
    import pwmg_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] src_level = 8'h00;
    logic [31:0] rd_data;
    logic [7:0] cap_in, pwm_out, pwm_oe;
    logic irq;
    logic rd_seen = 1'b0;
    logic [31:0] exp_v;
    logic [31:0] exp_q[$];
    int failures = 0;
    int n_compared = 0;
    int p_val, c_val, pr, hi, per, n_edges;
    logic prev_o;

    pwmg_top DUT (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .cap_in(cap_in), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
        .irq(irq));
    pwmg_pins u_pins (.pwm_out(pwm_out), .pwm_oe(pwm_oe), .src_level(src_level), .cap_in(cap_in));

    initial begin
        forever #12.5 clk = ~clk;
    end

    // ****************************************************************
    // bus tasks and read monitor
    // ****************************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
    endtask

    always @(posedge clk) begin
        if (rd_seen) begin
            exp_v = exp_q.pop_front();
            `CHK("rd_data", exp_v, rd_data)
        end
        rd_seen <= rd_en;
    end

    task automatic wait_lvl(input int ch, input logic lvl, inout int cnt);
        int n;
        n = 0;
        while (pwm_out[ch] !== lvl && n < 9000) begin
            @(posedge clk);
            n++;
        end
        cnt += n;
    endtask

    // high time and rising-to-rising period in clocks
    task automatic measure(input int ch, output int h, output int p);
        h = 0;
        p = 0;
        wait_lvl(ch, 1'b0, p);
        wait_lvl(ch, 1'b1, p);
        wait_lvl(ch, 1'b0, h);
        p = h;
        wait_lvl(ch, 1'b1, p);
    endtask

    task automatic print_verdict();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        print_verdict();
    end

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        void'($urandom(47813));
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(8'h20, 32'h0000_FFFF);
        rd(8'h40, 32'h0000_0000);
        wr(8'hF0, 32'hFFFF_FFFF);
        rd(8'hF0, 32'h0);
        wr(8'h60, 32'h1234);
        rd(8'h60, 32'h0);
        pr = $urandom_range(255);
        wr(8'h00, 32'(pr));
        rd(8'h00, 32'(pr));
        wr(8'h04, 32'h0000_7777);
        rd(8'h04, 32'h0000_4444);
        wr(8'hC0, 32'h0006_0006);
        rd(8'hC0, 32'h0006_0006);
        wr(8'hC4, 32'h0006_0006);
        rd(8'hC4, 32'h0006_0006);
        wr(8'hC0, 32'h0);
        wr(8'hC4, 32'h0);
        // period and duty over every divide code
        p_val = 4 + $urandom_range(12);
        c_val = 1 + $urandom_range(p_val - 2);
        pr = $urandom_range(3);
        wr(8'h20, 32'(p_val));
        wr(8'h40, 32'(c_val));
        wr(8'h00, 32'(pr));
        wr(8'h08, 32'h0000_0101);
        for (int d = 0; d < 5; d++) begin
            wr(8'h04, 32'(d));
            measure(0, hi, per);
            measure(0, hi, per);
            `CHK("period", (p_val + 1) * ((pr + 1) << d), per)
            `CHK("high", (c_val + 1) * ((pr + 1) << d), hi)
        end
        rd(8'h14, 32'h0000_0001);
        `CHK("irq masked", 1'b0, irq)
        wr(8'h10, 32'h1);
        @(posedge clk);
        `CHK("irq", 1'b1, irq)
        wr(8'h08, 32'h0);
        wr(8'h10, 32'h0);
        wr(8'h14, 32'h0000_FF01);
        rd(8'h14, 32'h0);
        // one-shot gives a single pulse
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h0000_0001);
        n_edges = 0;
        prev_o = 1'b0;
        repeat (4 * p_val + 20) begin
            @(posedge clk);
            if (pwm_out[0] === 1'b1 && prev_o === 1'b0) n_edges++;
            prev_o = pwm_out[0];
        end
        `CHK("pulses", 1, n_edges)
        rd(8'h60, 32'h0);
        rd(8'h14, 32'h0000_0001);
        // complementary pair with dead time 2
        wr(8'h08, 32'h0);
        wr(8'h14, 32'hFF);
        wr(8'h0C, 32'h2);
        p_val = 20 + $urandom_range(10);
        c_val = 6 + $urandom_range(6);
        wr(8'h20, 32'(p_val));
        wr(8'h40, 32'(c_val));
        wr(8'h08, 32'h0001_0102);
        repeat (8) @(posedge clk);
        `CHK("odd idle", 1'b0, pwm_out[1])
        wr(8'h08, 32'h0001_0103);
        measure(0, hi, per);
        `CHK("even high", c_val - 1, hi)
        `CHK("pair period", p_val + 1, per)
        measure(1, hi, per);
        `CHK("odd high", p_val - c_val - 2, hi)
        // capture on channel 2 after its timer is set up
        wr(8'h08, 32'h0);
        wr(8'h14, 32'hFF);
        wr(8'h28, 32'h5);
        wr(8'h08, 32'h0000_0004);
        repeat (20) @(posedge clk);
        rd(8'h68, 32'h0);
        wr(8'h00, 32'h0000_FF00);
        wr(8'h04, 32'h0000_0040);
        wr(8'hC4, 32'h0000_0003);
        `CHK("oe", 1'b0, pwm_oe[2])
        src_level <= 8'h04;
        repeat (8) @(posedge clk);
        rd(8'h88, 32'h0);
        rd(8'hC4, 32'h0000_0013);
        rd(8'h14, 32'h0000_0404);
        rd(8'h68, 32'h5);
        `CHK("irq capture", 1'b1, irq)
        wr(8'h14, 32'h0000_0404);
        src_level <= 8'h00;
        repeat (8) @(posedge clk);
        rd(8'hA8, 32'h5);
        rd(8'h14, 32'h0);
        `CHK("irq cleared", 1'b0, irq)
        // second rise latches the reloaded count
        src_level <= 8'h04;
        repeat (8) @(posedge clk);
        rd(8'h88, 32'h5);
        repeat (2) @(posedge clk);
        print_verdict();
    end
endmodule

`default_nettype wire
